// ### aip_pkg.sv
// Constants and carrier types for the page-load receiver
package aip_pkg;

   // Cycle framing
   localparam logic [3:0] START_FW_WRITE = 4'he;  // Write-cycle start code
   localparam logic [2:0] ADDR_NIBS_LAST = 3'h6;  // Seven address nibbles
   localparam int         ADDR_W         = 28;    // Full address width
   localparam int         PAGE_MSB       = 20;    // Top address bit used
   localparam int         PAGE_LSB       = 7;     // Lowest page bit used
   localparam int         PAGE_W         = PAGE_MSB - PAGE_LSB + 1;
   localparam logic [6:0] PAGE_LAST      = 7'h7f; // Byte 127 of the page

   // Internal load buffer: one group of bytes per hand-over
   localparam int         GROUP_BYTES = 16;
   localparam int         GIDX_W      = 4;
   localparam int         GCNT_W      = 5;
   localparam logic [GIDX_W-1:0] GROUP_LAST = 4'hf;

   // Bit positions in the link-side synchroniser vector
   localparam int SY_STRAP  = 0;  // Four strap pins, bits 3..0
   localparam int SY_MODE   = 4;  // Supervoltage mode pin
   localparam int SY_STROBE = 5;  // Load strobe, active low
   localparam int SY_READY  = 6;  // Ready flag from the system side
   localparam int SY_ACK    = 7;  // Ack toggle from the system side
   localparam int SY_W      = 8;

   // Reset values
   localparam logic READY_RST = 1'b1;  // Ready from reset onward

   // Per-byte programming time
   localparam int PROG_TIME_NS   = 400;
   localparam int SYS_PERIOD_NS  = 40;
   localparam int PROG_CYCLES    =
      (PROG_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int TIMER_W        = 8;
   localparam logic [TIMER_W-1:0] PROG_LOAD =
      TIMER_W'(PROG_CYCLES - 1);

   // Group request passed from the link side
   typedef struct packed {
      logic              last;   // Final group of the command
      logic [GCNT_W-1:0] count;  // Complete bytes in the group
      logic [6:0]        base;   // Page offset of first byte
      logic [PAGE_W-1:0] page;   // Page number
   } aip_req_s;

   // One byte handed to the array
   typedef struct packed {
      logic [PAGE_W-1:0] page;   // Page number
      logic [6:0]        offset; // Byte within page
      logic [7:0]        data;   // Byte value
   } aip_prog_s;

endpackage : aip_pkg

// ### aip_page_load.sv
// Auto-increment page-load receiver with programming sequencer
`timescale 1ns/100ps

module aip_page_load (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   sysCe,
   input  wire logic                   lclk,
   input  wire logic                   lframeN,
   input  wire logic [3:0]             lad,
   input  wire logic                   protect_supervoltage_mode_pin,
   input  wire logic                   load_strobe_n,
   input  wire logic [3:0]             strap_select_pins,
   output logic                        load_ready_flag,
   output logic                        progStrobe,
   output aip_pkg::aip_prog_s          progWord,
   output logic                        progBusy,
   output logic                        pageDone
);
   import aip_pkg::*;

   // Link-side parser states
   typedef enum logic [2:0] {
      L_IDLE, L_SEL, L_ADDR, L_SIZE, L_DATA, L_FINAL
   } aip_link_e;

   // System-side programming states
   typedef enum logic [1:0] {
      P_IDLE, P_WRITE, P_WAIT, P_DONE
   } aip_prog_e;

   // ---------------- Link clock domain ----------------
   logic [SY_W-1:0]         linkMeta;     // First synchroniser stage
   logic [SY_W-1:0]         linkSync;     // Second stage, safe to use
   aip_link_e               linkState;    // Nibble position
   logic                    startOk;      // Latest start nibble valid
   logic [2:0]              addrCnt;      // Address nibble count
   logic [ADDR_W-1:0]       addrShift;    // Address shift register
   logic [3:0]              lowNib;       // Held low data nibble
   logic                    nibHigh;      // Next nibble is high half
   logic [6:0]              byteIdx;      // Next byte in page
   logic [GIDX_W-1:0]       groupCnt;     // Bytes held in group
   logic [7:0]              groupMem [GROUP_BYTES]; // Load buffer
   logic                    pending;      // Group handed over
   logic                    reqToggle;    // Request event
   aip_req_s                reqInfo;      // Request contents
   logic                    ackSeen;      // Last ack level taken

   // ---------------- System clock domain ----------------
   logic                    sysMeta;      // Request first stage
   logic                    sysSync;      // Request second stage
   logic                    reqSeen;      // Last request level taken
   aip_prog_e               progState;    // Sequencer state
   aip_req_s                sysInfo;      // Latched request
   logic [GCNT_W-1:0]       idx;          // Byte within group
   logic [TIMER_W-1:0]      timer;        // Per-byte wait
   logic                    ackToggle;    // Ack event

   // Link-side decode, plus the system-side request edge
   logic strobeHigh;
   logic readyLink;
   logic ackEdge;
   logic capture;
   logic byteDone;
   logic lastByte;
   logic groupFull;
   logic issueFull;
   logic issueEnd;
   logic issueReq;
   logic issueLast;
   logic reqEdge;

   // Pins and system-side levels cross on two flops
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) begin
         linkMeta <= '0;
         linkSync <= '0;
      end else begin
         linkMeta <= {ackToggle, load_ready_flag, load_strobe_n,
                      protect_supervoltage_mode_pin, strap_select_pins};
         linkSync <= linkMeta;
      end
   end

   // Decode of capture and hand-over conditions
   always_comb begin
      strobeHigh = linkSync[SY_STROBE];
      readyLink  = linkSync[SY_READY];
      ackEdge    = linkSync[SY_ACK] != ackSeen;
      // Pending also gates capture, covering the ready lag
      capture    = (linkState == L_DATA) && lframeN && !pending &&
                   readyLink && !strobeHigh;
      byteDone   = capture && nibHigh;
      lastByte   = byteIdx == PAGE_LAST;
      groupFull  = groupCnt == GROUP_LAST;
      issueFull  = byteDone && (groupFull || lastByte);
      issueEnd   = (linkState == L_DATA) && lframeN && !pending &&
                   strobeHigh;
      issueReq   = issueFull || issueEnd;
      issueLast  = issueEnd || (byteDone && lastByte);
   end

   // Nibble position tracking
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) begin
         linkState <= L_IDLE;
         startOk   <= 1'b0;
         addrCnt   <= '0;
         addrShift <= '0;
      end else if (!lframeN) begin
         // Any start nibble restarts; the last one wins
         linkState <= L_SEL;
         startOk   <= (lad == START_FW_WRITE) &&
                      linkSync[SY_MODE];
      end else begin
         case (linkState)
            L_SEL: begin
               // Frame released: select or stand aside
               if (startOk &&
                   lad == linkSync[SY_STRAP +: 4]) begin
                  linkState <= L_ADDR;
                  addrCnt   <= '0;
               end else begin
                  linkState <= L_IDLE;
               end
            end
            L_ADDR: begin
               // Most significant nibble enters first
               addrShift <= {addrShift[ADDR_W-5:0], lad};
               addrCnt   <= addrCnt + 3'h1;
               if (addrCnt == ADDR_NIBS_LAST) begin
                  linkState <= L_SIZE;
               end
            end
            L_SIZE: begin
               // Size nibble taken and dropped
               linkState <= L_DATA;
            end
            L_DATA: begin
               if (issueReq && issueLast) begin
                  linkState <= L_FINAL;
               end
            end
            L_FINAL: begin
               // Held until the last group is programmed
               if (ackEdge) begin
                  linkState <= L_IDLE;
               end
            end
            L_IDLE: begin
               linkState <= L_IDLE;
            end
            default: begin
               linkState <= L_IDLE;
            end
         endcase
      end
   end

   // Data nibble assembly into the group buffer
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) begin
         lowNib   <= '0;
         nibHigh  <= 1'b0;
         byteIdx  <= '0;
         groupCnt <= '0;
      end else if (linkState == L_SIZE) begin
         // Page always fills from its first byte
         nibHigh  <= 1'b0;
         byteIdx  <= '0;
         groupCnt <= '0;
      end else if (issueEnd) begin
         // A lone low nibble is thrown away
         nibHigh  <= 1'b0;
         groupCnt <= '0;
      end else if (capture) begin
         if (!nibHigh) begin
            lowNib  <= lad;
            nibHigh <= 1'b1;
         end else begin
            nibHigh  <= 1'b0;
            byteIdx  <= byteIdx + 7'h01;
            groupCnt <= groupFull ? '0 : groupCnt + 4'h1;
         end
      end
   end

   // Buffer storage; no reset needed for data words
   always_ff @(posedge lclk) begin
      if (byteDone) begin
         groupMem[groupCnt] <= {lad, lowNib};
      end
   end

   // Group hand-over request and ack tracking
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) begin
         pending   <= 1'b0;
         reqToggle <= 1'b0;
         reqInfo   <= '0;
         ackSeen   <= 1'b0;
      end else begin
         if (ackEdge) begin
            ackSeen <= ~ackSeen;
            pending <= 1'b0;
         end
         if (issueReq) begin
            // Contents settle long before the far side looks
            reqInfo.last  <= issueLast;
            reqInfo.count <= issueEnd ? {1'b0, groupCnt}
                                      : {1'b0, groupCnt} + 5'h01;
            reqInfo.base  <= byteIdx - {3'h0, groupCnt};
            reqInfo.page  <= addrShift[PAGE_MSB:PAGE_LSB];
            reqToggle     <= ~reqToggle;
            pending       <= 1'b1;
         end
      end
   end

   // Request toggle crosses on two flops
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sysMeta <= 1'b0;
         sysSync <= 1'b0;
      end else if (sysCe) begin
         sysMeta <= reqToggle;
         sysSync <= sysMeta;
      end
   end

   assign reqEdge = sysSync != reqSeen;

   // Programming sequencer, one byte at a time
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         progState <= P_IDLE;
         reqSeen   <= 1'b0;
         sysInfo   <= '0;
         idx       <= '0;
         timer     <= '0;
      end else if (sysCe) begin
         case (progState)
            P_IDLE: begin
               if (reqEdge) begin
                  reqSeen <= ~reqSeen;
                  sysInfo <= reqInfo;
                  idx     <= '0;
                  // Empty final group still ends the command
                  progState <= (reqInfo.count == '0) ? P_DONE
                                                     : P_WRITE;
               end
            end
            P_WRITE: begin
               timer     <= PROG_LOAD;
               progState <= P_WAIT;
            end
            P_WAIT: begin
               if (timer == '0) begin
                  if (idx == sysInfo.count - 5'h01) begin
                     progState <= P_DONE;
                  end else begin
                     idx       <= idx + 5'h01;
                     progState <= P_WRITE;
                  end
               end else begin
                  timer <= timer - 8'h01;
               end
            end
            P_DONE: begin
               progState <= P_IDLE;
            end
            default: begin
               progState <= P_IDLE;
            end
         endcase
      end
   end

   // Ready flag lives here so it can rise with the link clock stopped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         load_ready_flag <= READY_RST;
         ackToggle       <= 1'b0;
      end else if (sysCe) begin
         if (progState == P_IDLE && reqEdge) begin
            load_ready_flag <= 1'b0;
         end else if (progState == P_DONE) begin
            load_ready_flag <= 1'b1;
            ackToggle       <= ~ackToggle;
         end
      end
   end

   // Byte write port towards the array
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         progStrobe <= 1'b0;
         progWord   <= '0;
      end else if (sysCe) begin
         progStrobe <= progState == P_WRITE;
         if (progState == P_WRITE) begin
            // Buffer is frozen while the group is pending
            progWord.page   <= sysInfo.page;
            progWord.offset <= sysInfo.base + {2'h0, idx};
            progWord.data   <= groupMem[idx[GIDX_W-1:0]];
         end
      end
   end

   // Command status
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         progBusy <= 1'b0;
         pageDone <= 1'b0;
      end else if (sysCe) begin
         pageDone <= (progState == P_DONE) && sysInfo.last;
         if (progState == P_IDLE && reqEdge) begin
            progBusy <= 1'b1;
         end else if (progState == P_DONE) begin
            progBusy <= 1'b0;
         end
      end
   end

endmodule : aip_page_load

// ### aip_page_load_props.sv
// Concurrent checks on the page-load receiver ports
`timescale 1ns/100ps

module aip_page_load_props (
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               load_ready_flag,
   input wire logic               progStrobe,
   input wire aip_pkg::aip_prog_s progWord,
   input wire logic               progBusy,
   input wire logic               pageDone
);
   // One domain only, so clock and reset are given once
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Idle values must survive the first edge after release
   property p_rst_idle;
      $fell(rst) |-> load_ready_flag && !progBusy && !progStrobe;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("outputs not idle after reset");

   // Bytes of a group are spaced at least eleven clocks apart
   property p_strobe_gap;
      progStrobe |=> !progStrobe[*8] ##1 !progStrobe[*2];
   endproperty
   a_strobe_gap: assert property (p_strobe_gap)
      else $error("program strobes too close");

   // Consecutive bytes climb by one page offset
   property p_prog_step;
      progStrobe ##11 progStrobe |->
         progWord.offset == $past(progWord.offset, 11) + 7'h01;
   endproperty
   a_prog_step: assert property (p_prog_step)
      else $error("page offset did not step by one");

   // Buffer busy while its bytes are programmed
   property p_ready_busy;
      progStrobe |-> !load_ready_flag;
   endproperty
   a_ready_busy: assert property (p_ready_busy)
      else $error("ready high during programming");

   // Strobes only inside a busy group
   property p_strobe_busy;
      progStrobe |-> progBusy;
   endproperty
   a_strobe_busy: assert property (p_strobe_busy)
      else $error("strobe outside busy group");

   // Completion is a single pulse
   property p_done_pulse;
      pageDone |=> !pageDone;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("completion pulse too long");

   // Ready returns with command completion
   property p_done_ready;
      pageDone |-> ##[0:4] load_ready_flag;
   endproperty
   a_done_ready: assert property (p_done_ready)
      else $error("ready not back after completion");

   // Byte word holds between strobes
   property p_word_hold;
      !progStrobe |-> $stable(progWord);
   endproperty
   a_word_hold: assert property (p_word_hold)
      else $error("program word changed without strobe");
endmodule : aip_page_load_props

// ### aip_host_model.sv
// Host model that drives load cycles on the link
`timescale 1ns/100ps

module aip_host_model (
   output logic       lclk,
   output logic       lframeN,
   output logic [3:0] lad,
   output logic       loadStrobeN,
   input  wire logic  readyFlag,
   input  wire logic  sys_clk
);
   // Link clock stands still outside ticks
   initial begin
      lclk = 1'b0;
      lframeN = 1'b1;
      lad = 4'h0;
      loadStrobeN = 1'b1;
   end

   // One link edge with a nibble set up half a period ahead
   task automatic tick(input logic [3:0] nib);
      lad = nib;
      #6 lclk = 1'b1;
      #6 lclk = 1'b0;
   endtask : tick

   // Released bus toggles so stale values never look valid
   task automatic idle(input int n);
      repeat (n) tick(~lad);
   endtask : idle

   // Stop until the group is programmed, then resync
   task automatic pause();
      int k;
      idle(4);
      k = 0;
      while (readyFlag === 1'b1 && k < 60) begin
         @(posedge sys_clk);
         k++;
      end
      k = 0;
      while (readyFlag !== 1'b1 && k < 1000) begin
         @(posedge sys_clk);
         k++;
      end
      idle(3);
   endtask : pause

   // Whole load cycle; served says whether the device answers
   task automatic load(input logic [7:0] st, input int nSt,
      input logic [3:0] sel, input logic [27:0] a, input int n,
      input bit lone, input bit served);
      int i;
      logic [7:0] b;
      loadStrobeN = 1'b0;
      idle(4);
      lframeN = 1'b0;
      for (i = nSt - 1; i >= 0; i--) tick(st[4*i +: 4]);
      lframeN = 1'b1;
      tick(sel);
      for (i = 6; i >= 0; i--) tick(a[4*i +: 4]);
      tick(4'h7);
      // Strobe crosses two link flops, so it rises two nibbles early
      for (i = 0; i < 2 * n; i++) begin
         b = 8'(i / 2 * 37 + 5);
         if (n < 128 && i == 2 * n - (lone ? 1 : 2)) loadStrobeN = 1'b1;
         tick(i % 2 ? b[7:4] : b[3:0]);
         if (served && (i % 32 == 31)) pause();
      end
      if (lone) tick(4'h9);
      if (n < 128 && served) pause();
      loadStrobeN = 1'b1;
      idle(2);
   endtask : load
endmodule : aip_host_model

// ### aip_tb.sv
// Self-checking bench for the page-load receiver
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
 $display("mismatch %0t got %h exp %h", $time, a, b); end end

module testbench;
   import aip_pkg::*;
   logic       sys_clk, rst, sysCe, modePin;
   logic [3:0] strapPins;
   logic       lclk, lframeN, loadStrobeN, readyFlag;
   logic [3:0] lad;
   logic       progStrobe, progBusy, pageDone;
   aip_prog_s  progWord;
   aip_prog_s  got[$];     // Bytes seen at the program port
   int         doneCnt;    // Completion pulses seen
   int         err_total, n_checks;

   // 25 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   aip_page_load u_dut (.sys_clk(sys_clk), .rst(rst), .sysCe(sysCe),
      .lclk(lclk), .lframeN(lframeN), .lad(lad),
      .protect_supervoltage_mode_pin(modePin),
      .load_strobe_n(loadStrobeN), .strap_select_pins(strapPins),
      .load_ready_flag(readyFlag), .progStrobe(progStrobe),
      .progWord(progWord), .progBusy(progBusy), .pageDone(pageDone));

   aip_host_model u_host (.lclk(lclk), .lframeN(lframeN), .lad(lad),
      .loadStrobeN(loadStrobeN), .readyFlag(readyFlag), .sys_clk(sys_clk));

   // Collect program traffic for later comparison
   always @(posedge sys_clk) begin
      if (progStrobe === 1'b1) got.push_back(progWord);
      if (pageDone === 1'b1) doneCnt++;
   end

   // Compare collected bytes against the expected page
   task automatic expect_page(input logic [27:0] a, input int n,
      input int done);
      int i;
      repeat (20) @(posedge sys_clk);
      `CHK(got.size(), n)
      for (i = 0; i < got.size() && i < n; i++) begin
         `CHK(got[i].page, a[20:7])
         `CHK(got[i].offset, 7'(i))
         `CHK(got[i].data, 8'(i * 37 + 5))
      end
      `CHK(doneCnt, done)
      `CHK(readyFlag, 1'b1)
      got.delete();
      doneCnt = 0;
   endtask : expect_page

   // Verdict and end of run
   task results();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   // Main sequence
   initial begin
      err_total = 0;
      n_checks = 0;
      doneCnt = 0;
      rst <= 1'b1;
      sysCe <= 1'b1;
      modePin <= 1'b1;
      strapPins <= 4'h5;
      fork
         u_host.idle(8);
         repeat (6) @(posedge sys_clk);
      join
      `CHK(readyFlag, 1'b1)
      `CHK(progBusy, 1'b0)
      rst <= 1'b0;
      u_host.load(8'h0e, 1, 4'h5, 28'hab5c3f1, 128, 0, 1);
      expect_page(28'hab5c3f1, 128, 1);
      $display("test full_page done");
      fork
         u_host.load(8'h3e, 2, 4'h5, 28'h0ffff80, 5, 1, 1);
         begin
            // Freeze the system side mid-group; nothing may move
            @(posedge progStrobe);
            @(posedge sys_clk);
            sysCe <= 1'b0;
            repeat (30) @(posedge sys_clk);
            `CHK(got.size(), 1)
            `CHK(readyFlag, 1'b0)
            `CHK(progBusy, 1'b1)
            sysCe <= 1'b1;
         end
      join
      expect_page(28'h0ffff80, 5, 1);
      $display("test partial_page done");
      u_host.load(8'he3, 2, 4'h5, 28'h0000100, 3, 0, 0);
      expect_page(28'h0000100, 0, 0);
      $display("test bad_start done");
      u_host.load(8'h0e, 1, 4'ha, 28'h0000200, 3, 0, 0);
      expect_page(28'h0000200, 0, 0);
      u_host.load(8'h0e, 1, 4'h5, 28'h0012345, 2, 0, 1);
      expect_page(28'h0012345, 2, 1);
      $display("test strap_mismatch done");
      @(posedge sys_clk);
      modePin <= 1'b0;
      u_host.load(8'h0e, 1, 4'h5, 28'h0000300, 3, 0, 0);
      expect_page(28'h0000300, 0, 0);
      $display("test mode_low done");
      results();
   end

   // Watchdog against a hung handshake
   initial begin
      #400000;
      err_total++;
      $display("mismatch %0t watchdog expired", $time);
      results();
   end
endmodule : testbench

bind aip_page_load aip_page_load_props u_props (.sys_clk(sys_clk),
   .rst(rst), .load_ready_flag(load_ready_flag),
   .progStrobe(progStrobe), .progWord(progWord),
   .progBusy(progBusy), .pageDone(pageDone));
